// ==== common/mcc_defs.svh ====
// Constants of the monitor control configuration register bank.
// Assumes a system clock of 200 MHz and an 8-bit serial register port.
`ifndef MCC_DEFS_SVH
`define MCC_DEFS_SVH
`define MCC_ADDR_W      7
`define MCC_CC1_ADDR    7'h18
`define MCC_CC2_ADDR    7'h19
`define MCC_CC3_ADDR    7'h1A
`define MCC_CC_RST      8'h00
`define MCC_CC1_WMASK   8'hEF
`define MCC_CC2_WMASK   8'h77
`define MCC_CC3_WMASK   8'h7B
`define MCC_CC1_RUN     0
`define MCC_CC1_PAIR    1
`define MCC_CC1_PIN9    3
`define MCC_CC1_INTDIS  5
`define MCC_CC1_INTPOL  6
`define MCC_CC1_PD      7
`define MCC_CC2_CH      0
`define MCC_CC2_SINGLE  4
`define MCC_CC2_AVGDIS  5
`define MCC_CC2_TMO     6
`define MCC_CC2_SRST    7
`define MCC_CC3_FAST    0
`define MCC_CC3_RES10   1
`define MCC_CC3_UPDREG  3
`define MCC_CC3_REFVDD  4
`define MCC_CC3_THA     5
`define MCC_CC3_THB     6
`define MCC_PAIR_AIN    2'h0
`define MCC_PAIR_DIODE  2'h2
`define MCC_DAC_LOAD_STROBE_REG    2'h3
`define MCC_AVG_N       5'h10
`define MCC_AVG_ONE     5'h01
`define MCC_SYS_HZ      200000000
`define MCC_TMO_MS      25
`define MCC_SLOW_KHZ_X10 14
`define MCC_FAST_KHZ_X10 225
`define MCC_CNT_W       24
`endif

// ==== common/mcc_pkg.sv ====
// Types of the monitor control configuration register bank.
// Assumes mcc_defs.svh is on the include path.
package mcc_pkg;
`include "mcc_defs.svh"
  typedef enum logic [7:0] {
    MCC_SRC_SUPPLY = 8'h01,
    MCC_SRC_TEMP_INT = 8'h02,
    MCC_SRC_TEMP_EXT = 8'h04,
    MCC_SRC_ANALOG_INPUT_FIRST = 8'h08,
    MCC_SRC_ANALOG_INPUT_SECOND = 8'h10,
    MCC_SRC_ANALOG_INPUT_THIRD = 8'h20,
    MCC_SRC_ANALOG_INPUT_FOURTH = 8'h40,
    MCC_SRC_NONE = 8'h80
  } mcc_src_t;
  typedef struct packed {
    logic [7:0] cc1;
    logic [7:0] cc2;
    logic [7:0] cc3;
    logic [7:0] rd_hold;
    logic [2:0] tg_s;
    logic       tg_st;
    logic [2:0] ck_s;
    logic       ck_st;
    logic [2:0] cs_s;
    logic       cs_st;
    logic [2:0] ls_s;
    logic       ls_st;
    logic [`MCC_CNT_W-1:0] tmo_cnt;
    logic       tmo_hit;
    logic [`MCC_CNT_W-1:0] adc_cnt;
    logic       adc_tick;
    logic       srst;
    logic       pin_load;
  } mcc_sys_t;
  typedef struct packed {
    logic [3:0] bit_cnt;
    logic [6:0] sh_in;
    logic [7:0] sh_out;
    logic       is_rd;
    logic [`MCC_ADDR_W-1:0] addr;
  } mcc_frm_t;
  typedef struct packed {
    logic       tgl;
    logic       rd;
    logic [`MCC_ADDR_W-1:0] addr;
    logic [7:0] data;
  } mcc_lnk_t;
endpackage

// ==== testbench/mcc_host_model.sv ====
// Host side serial master for the control register bank.
// Assumes the bank samples data on rising serial clock edges; the serial
// clock stands low between frames.
module mcc_host_model (
  output logic      o_sck,
  output logic      o_cs_n,
  output logic      o_mosi,
  input  wire logic i_miso,
  input  wire logic i_miso_oe
);
  timeunit 1ns;
  timeprecision 100ps;
  localparam int HALF = 24;
  logic miso_last = 1'b0;
  logic miso_line;
  // A released line shows the inverse of its last value, so a missing
  // enable cannot pass for good data
  always @(i_miso or i_miso_oe) begin
    if (i_miso_oe === 1'b1) miso_last = i_miso;
  end
  assign miso_line = (i_miso_oe === 1'b1) ? i_miso : ~miso_last;
  initial begin
    o_sck = 1'b0;
    o_cs_n = 1'b1;
    o_mosi = 1'b0;
  end
  // One 16 bit frame; read data is sampled before rises 9 to 16
  task automatic xfer(input logic [7:0] b0, input logic [7:0] b1,
                      output logic [7:0] rd);
    logic [15:0] w;
    w = {b0, b1};
    rd = 8'h00;
    o_cs_n = 1'b0;
    #HALF;
    for (int i = 15; i >= 0; i--) begin
      o_mosi = w[i];
      #HALF;
      if (i < 8) rd = {rd[6:0], miso_line};
      o_sck = 1'b1;
      #HALF;
      o_sck = 1'b0;
    end
    #HALF;
    o_cs_n = 1'b1;
    o_mosi = ~o_mosi;
    #120;
  endtask
  task automatic sel(input logic v);
    o_cs_n = v;
  endtask
endmodule

// ==== testbench/mcc_regs_tb.sv ====
// Self-checking bench for the control configuration register bank.
// Assumes the bank is reached only through the serial host model.
`include "mcc_defs.svh"
module mcc_regs_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import mcc_pkg::*;
  logic i_sys_clk = 1'b0;
  logic i_arst_n = 1'b0;
  logic i_int_event;
  logic i_dac_load_strobe_n;
  logic [1:0] i_dac_cfg_dac_load_strobe_mode;
  logic sck, cs_n, mosi, miso, miso_oe, int_out, int_oe, run, single;
  logic dio, pair, pin9, stby, tmo, srst, tick, fast, filt, res10;
  logic regupd, pinload, ldreg, refvdd, tha, thb;
  logic [4:0] avg;
  mcc_src_t src;
  int n_fail = 0;
  int n_tests = 0;
  int cyc = 0;
  int n_tick = 0;
  int n_load = 0;
  int n_srst = 0;
  logic [7:0] rv;
  always #2.5 i_sys_clk = ~i_sys_clk;
  // Short counts keep the run brief; expectations use the same values
  mcc_regs #(.TMO_CYC(50), .SLOW_CYC(20), .FAST_CYC(5)) dut (
    .i_sys_clk(i_sys_clk), .i_arst_n(i_arst_n), .i_spi_sck(sck),
    .i_spi_cs_n(cs_n), .i_spi_mosi(mosi), .o_spi_miso(miso),
    .o_spi_miso_oe(miso_oe), .i_int_event(i_int_event),
    .o_int_out(int_out), .o_int_oe(int_oe),
    .i_dac_load_strobe_n(i_dac_load_strobe_n),
    .i_dac_cfg_dac_load_strobe_mode(i_dac_cfg_dac_load_strobe_mode), .o_monitor_run(run),
    .o_single_mode(single), .o_conv_src(src), .o_ext_diode_sel(dio),
    .o_ain_pair_sel(pair), .o_pin9_analog(pin9), .o_standby(stby),
    .o_avg_count(avg), .o_bus_timeout(tmo), .o_soft_reset(srst),
    .o_adc_tick(tick), .o_adc_fast(fast), .o_diode_filter_en(filt),
    .o_therm_dac_10bit(res10), .o_dac_reg_update(regupd),
    .o_dac_pin_load(pinload), .o_dac_load_strobe_reg_only(ldreg),
    .o_adc_ref_vdd(refvdd), .o_dac_a_therm(tha), .o_dac_b_therm(thb));
  mcc_host_model host (.o_sck(sck), .o_cs_n(cs_n), .o_mosi(mosi),
    .i_miso(miso), .i_miso_oe(miso_oe));
  task automatic conclude();
    $display("tests %0d failures %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // Pulses are counted on the falling edge, where they have settled
  always @(negedge i_sys_clk) begin
    cyc++;
    if (tick === 1'b1) n_tick++;
    if (pinload === 1'b1) n_load++;
    if (srst === 1'b1) n_srst++;
    if (cyc == 40000) begin
      n_fail++;
      conclude();
    end
  end
  task automatic chk(input string nm, input logic [7:0] e,
                     input logic [7:0] g);
    n_tests++;
    if (g !== e) begin
      n_fail++;
      $display("wrong value %s expected %0h seen %0h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    logic [7:0] x;
    // Callers keep reserved bits at zero
    host.xfer({1'b0, a}, d, x);
  endtask
  // Second frame fetches what the first one requested
  task automatic rd(input logic [6:0] a, output logic [7:0] d);
    logic [7:0] x;
    host.xfer({1'b1, a}, 8'h00, x);
    host.xfer({1'b1, a}, 8'h00, d);
  endtask
  task automatic ticks(input int e);
    int n0;
    @(posedge i_sys_clk);
    n0 = n_tick;
    repeat (100) @(posedge i_sys_clk);
    chk("ticks", e, n_tick - n0);
  endtask
  task automatic t_reset();
    chk("run", 8'h00, run);
    chk("int_oe", 8'h01, int_oe);
    chk("src", 8'h01, src);
    chk("pair", 8'h01, pair);
    chk("single", 8'h00, single);
    chk("avg", 8'h10, avg);
    for (int a = 8'h18; a <= 8'h1A; a++) begin
      rd(a[6:0], rv);
      chk("reg reset", `MCC_CC_RST, rv);
    end
    rd(7'h20, rv);
    chk("unmapped", 8'h00, rv);
  endtask
  task automatic t_run();
    wr(`MCC_CC1_ADDR, 8'h01);
    chk("run", 8'h01, run);
    ticks(5);
    wr(`MCC_CC3_ADDR, 8'h01);
    chk("fast", 8'h01, fast);
    chk("filter", 8'h00, filt);
    ticks(20);
    wr(`MCC_CC1_ADDR, 8'h81);
    chk("standby", 8'h01, stby);
    chk("run", 8'h00, run);
    ticks(0);
    rd(`MCC_CC1_ADDR, rv);
    chk("cc1", 8'h81, rv);
    wr(`MCC_CC1_ADDR, 8'h00);
    chk("standby", 8'h00, stby);
    ticks(0);
    wr(`MCC_CC3_ADDR, 8'h00);
  endtask
  task automatic t_int();
    logic en, pol;
    for (int i = 0; i < 8; i++) begin
      en = i[0];
      pol = i[1];
      wr(`MCC_CC1_ADDR, {1'b0, pol, en, 5'h00});
      @(posedge i_sys_clk);
      i_int_event <= i[2];
      repeat (2) @(posedge i_sys_clk);
      chk("int_oe", {7'h00, ~en}, int_oe);
      chk("int_out", {7'h00, pol ~^ i[2]}, int_out);
    end
    i_int_event <= 1'b0;
    wr(`MCC_CC1_ADDR, 8'h00);
  endtask
  task automatic t_chan();
    logic [7:0] e;
    for (int p = 0; p <= 2; p += 2) begin
      wr(`MCC_CC1_ADDR, p[7:0] << 1);
      chk("diode", {7'h00, p == 2}, dio);
      chk("pair", {7'h00, p == 0}, pair);
      for (int c = 0; c < 8; c++) begin
        wr(`MCC_CC2_ADDR, 8'h10 | c[7:0]);
        chk("single", 8'h01, single);
        e = (c < 6) ? (8'h01 << c) : 8'h80;
        if (c == 2) e = (p == 2) ? 8'h04 : 8'h08;
        if (c > 2 && c < 6) e = 8'h01 << (c + 1);
        chk("src", e, src);
      end
    end
    wr(`MCC_CC2_ADDR, 8'h00);
    wr(`MCC_CC1_ADDR, 8'h00);
  endtask
  task automatic strobe(input int e);
    int n0;
    n0 = n_load;
    @(posedge i_sys_clk);
    i_dac_load_strobe_n <= 1'b0;
    repeat (8) @(posedge i_sys_clk);
    i_dac_load_strobe_n <= 1'b1;
    repeat (8) @(posedge i_sys_clk);
    chk("pin_load", e, n_load - n0);
  endtask
  task automatic t_cc3();
    strobe(1);
    wr(`MCC_CC3_ADDR, 8'h7B);
    chk("res10", 8'h01, res10);
    chk("reg_upd", 8'h01, regupd);
    chk("ref_vdd", 8'h01, refvdd);
    chk("dac_a", 8'h01, tha);
    chk("dac_b", 8'h01, thb);
    strobe(0);
    @(posedge i_sys_clk);
    i_dac_cfg_dac_load_strobe_mode <= `MCC_DAC_LOAD_STROBE_REG;
    repeat (2) @(posedge i_sys_clk);
    chk("ld_reg", 8'h01, ldreg);
    wr(`MCC_CC1_ADDR, 8'h08);
    chk("pin9", 8'h01, pin9);
    chk("reg_upd", 8'h00, regupd);
    chk("ld_reg", 8'h00, ldreg);
    strobe(0);
    rd(`MCC_CC3_ADDR, rv);
    chk("cc3", 8'h7B, rv);
    @(posedge i_sys_clk);
    i_dac_cfg_dac_load_strobe_mode <= 2'h0;
    wr(`MCC_CC1_ADDR, 8'h00);
    wr(`MCC_CC3_ADDR, 8'h00);
  endtask
  task automatic t_tmo();
    for (int t = 1; t >= 0; t--) begin
      wr(`MCC_CC2_ADDR, {1'b0, t[0], 6'h00});
      host.sel(1'b0);
      repeat (70) @(posedge i_sys_clk);
      chk("timeout", {7'h00, t[0]}, tmo);
      host.sel(1'b1);
      repeat (20) @(posedge i_sys_clk);
      chk("timeout", 8'h00, tmo);
    end
    wr(`MCC_CC2_ADDR, 8'h20);
    chk("avg", 8'h01, avg);
  endtask
  task automatic t_srst();
    int n0;
    wr(`MCC_CC1_ADDR, 8'h61);
    wr(`MCC_CC3_ADDR, 8'h10);
    n0 = n_srst;
    wr(`MCC_CC2_ADDR, 8'h80);
    chk("srst", 8'h01, n_srst - n0);
    chk("int_oe", 8'h01, int_oe);
    chk("avg", 8'h10, avg);
    rd(`MCC_CC2_ADDR, rv);
    chk("cc2", 8'h00, rv);
    rd(`MCC_CC1_ADDR, rv);
    chk("cc1", 8'h00, rv);
    rd(`MCC_CC3_ADDR, rv);
    chk("cc3", 8'h00, rv);
  endtask
  initial begin
    i_int_event <= 1'b0;
    i_dac_load_strobe_n <= 1'b1;
    i_dac_cfg_dac_load_strobe_mode <= 2'h0;
    repeat (20) @(posedge i_sys_clk);
    i_arst_n <= 1'b1;
    repeat (5) @(posedge i_sys_clk);
    t_reset();
    t_run();
    t_int();
    t_chan();
    t_cc3();
    t_tmo();
    t_srst();
    conclude();
  end
endmodule

// ==== verilog/mcc_regs.sv ====
// Control configuration register bank with its serial register port.
// Assumes a free running i_sys_clk and a serial clock that may stop
// outside frames; the frame select pin ends every frame.
// Overview of operation
// - Start bit runs monitoring; clear stops it
// - Pair field: 00 two inputs, 10 diode
// - Pin function bit masks update-source bit
// - Interrupt pin driven only when enable 0
// - Polarity bit: 0 low, 1 high active
// - Standby bit powers down converters, port alive
// - Channel field picks single-channel source
// - Code 010 follows the pair field
// - Mode bit: 0 round robin, 1 single
// - Average sixteen times unless disabled
// - Timeout bit limits serial clock to 25 ms
// - Soft reset returns everything to defaults
// - Speed bit 1.4 or 22.5 kHz, filters
// - Resolution bit 8 or 10 bit thermal
// - Update source: strobe pin or registers
// - Reference select: internal or supply
// - Thermal bit routes internal temp to A
// - Thermal bit routes external temp to B
// - Register mode 11 takes load register only
module mcc_regs #(
  parameter int TMO_CYC  = `MCC_TMO_MS * (`MCC_SYS_HZ / 1000),
  parameter int SLOW_CYC = `MCC_SYS_HZ / (`MCC_SLOW_KHZ_X10 * 100),
  parameter int FAST_CYC = `MCC_SYS_HZ / (`MCC_FAST_KHZ_X10 * 100),
  parameter int DAC_BITS = 12
) (
  input  wire logic        i_sys_clk,
  input  wire logic        i_arst_n,
  input  wire logic        i_spi_sck,
  input  wire logic        i_spi_cs_n,
  input  wire logic        i_spi_mosi,
  output logic             o_spi_miso,
  output logic             o_spi_miso_oe,
  input  wire logic        i_int_event,
  output logic             o_int_out,
  output logic             o_int_oe,
  input  wire logic        i_dac_load_strobe_n,
  input  wire logic [1:0]  i_dac_cfg_dac_load_strobe_mode,
  output logic             o_monitor_run,
  output logic             o_single_mode,
  output mcc_pkg::mcc_src_t o_conv_src,
  output logic             o_ext_diode_sel,
  output logic             o_ain_pair_sel,
  output logic             o_pin9_analog,
  output logic             o_standby,
  output logic [4:0]       o_avg_count,
  output logic             o_bus_timeout,
  output logic             o_soft_reset,
  output logic             o_adc_tick,
  output logic             o_adc_fast,
  output logic             o_diode_filter_en,
  output logic             o_therm_dac_10bit,
  output logic             o_dac_reg_update,
  output logic             o_dac_pin_load,
  output logic             o_dac_load_strobe_reg_only,
  output logic             o_adc_ref_vdd,
  output logic             o_dac_a_therm,
  output logic             o_dac_b_therm
);
  import mcc_pkg::*;

  initial begin
    if (TMO_CYC < 1 || TMO_CYC >= (1 << `MCC_CNT_W) ||
        SLOW_CYC < 2 || SLOW_CYC >= (1 << `MCC_CNT_W) ||
        FAST_CYC < 2 || FAST_CYC >= (1 << `MCC_CNT_W) ||
        !(DAC_BITS == 8 || DAC_BITS == 10 || DAC_BITS == 12)) begin
      $error("mcc_regs: unsupported parameter value");
    end
  end

  localparam logic [`MCC_CNT_W-1:0] TMO_C =
    TMO_CYC[`MCC_CNT_W-1:0];
  localparam logic [`MCC_CNT_W-1:0] SLOW_C =
    SLOW_CYC[`MCC_CNT_W-1:0];
  localparam logic [`MCC_CNT_W-1:0] FAST_C =
    FAST_CYC[`MCC_CNT_W-1:0];

  function automatic mcc_src_t src_decode(
    input logic [2:0] ch,
    input logic [1:0] pair
  );
    mcc_src_t s;
    case (ch)
      3'h0: s = MCC_SRC_SUPPLY;
      3'h1: s = MCC_SRC_TEMP_INT;
      3'h2: s = (pair == `MCC_PAIR_DIODE) ? MCC_SRC_TEMP_EXT
                : MCC_SRC_ANALOG_INPUT_FIRST;
      3'h3: s = MCC_SRC_ANALOG_INPUT_SECOND;
      3'h4: s = MCC_SRC_ANALOG_INPUT_THIRD;
      3'h5: s = MCC_SRC_ANALOG_INPUT_FOURTH;
      default: s = MCC_SRC_NONE;
    endcase
    return s;
  endfunction

  // Serial clock domain
  mcc_frm_t f_r;
  mcc_frm_t f_nxt;
  mcc_lnk_t l_r;
  mcc_lnk_t l_nxt;
  mcc_sys_t s_r;
  mcc_sys_t s_nxt;

  always_comb begin
    f_nxt = f_r;
    l_nxt = l_r;
    f_nxt.bit_cnt = f_r.bit_cnt + 4'h1;
    f_nxt.sh_in = {f_r.sh_in[5:0], i_spi_mosi};
    f_nxt.sh_out = {f_r.sh_out[6:0], 1'b0};
    if (f_r.bit_cnt == 4'h7) begin
      f_nxt.is_rd = f_r.sh_in[6];
      f_nxt.addr = {f_r.sh_in[5:0], i_spi_mosi};
      // Snapshot was taken by the previous read frame and is quiet now
      f_nxt.sh_out = s_r.rd_hold;
    end
    if (f_r.bit_cnt == 4'hF) begin
      l_nxt.tgl = ~l_r.tgl;
      l_nxt.rd = f_r.is_rd;
      l_nxt.addr = f_r.addr;
      l_nxt.data = {f_r.sh_in, i_spi_mosi};
    end
  end

  // Frame state is cleared by the frame select, so no edge is needed
  always_ff @(posedge i_spi_sck or posedge i_spi_cs_n) begin
    if (i_spi_cs_n) begin
      f_r <= '0;
    end else begin
      f_r <= f_nxt;
    end
  end

  always_ff @(posedge i_spi_sck or negedge i_arst_n) begin
    if (!i_arst_n) begin
      l_r <= '0;
    end else begin
      l_r <= l_nxt;
    end
  end

  assign o_spi_miso = f_r.sh_out[7];
  // Released on timeout so a stuck clock cannot hold the data line
  assign o_spi_miso_oe = !i_spi_cs_n && f_r.is_rd
                         && !s_r.tmo_hit;

  // System clock domain
  logic wr_evt;
  logic rd_evt;
  logic run;
  logic upd_reg;
  logic [`MCC_CNT_W-1:0] adc_per;

  always_comb begin
    s_nxt = s_r;
    wr_evt = 1'b0;
    rd_evt = 1'b0;
    s_nxt.srst = 1'b0;
    s_nxt.pin_load = 1'b0;
    s_nxt.adc_tick = 1'b0;
    s_nxt.tg_s = {s_r.tg_s[1:0], l_r.tgl};
    s_nxt.ck_s = {s_r.ck_s[1:0], i_spi_sck};
    s_nxt.cs_s = {s_r.cs_s[1:0], i_spi_cs_n};
    s_nxt.ls_s = {s_r.ls_s[1:0], i_dac_load_strobe_n};
    if (s_r.tg_s[1] == s_r.tg_s[2]) begin
      s_nxt.tg_st = s_r.tg_s[2];
    end
    if (s_r.ck_s[1] == s_r.ck_s[2]) begin
      s_nxt.ck_st = s_r.ck_s[2];
    end
    if (s_r.cs_s[1] == s_r.cs_s[2]) begin
      s_nxt.cs_st = s_r.cs_s[2];
    end
    if (s_r.ls_s[1] == s_r.ls_s[2]) begin
      s_nxt.ls_st = s_r.ls_s[2];
    end
    if (s_r.tg_s[1] == s_r.tg_s[2] && s_r.tg_s[2] != s_r.tg_st
        && !s_r.tmo_hit) begin
      wr_evt = !l_r.rd;
      rd_evt = l_r.rd;
    end

    // Clock pulse width watchdog while a frame is open
    if (s_r.cs_st || s_nxt.ck_st != s_r.ck_st) begin
      s_nxt.tmo_cnt = '0;
    end else if (s_r.cc2[`MCC_CC2_TMO] && !s_r.tmo_hit) begin
      s_nxt.tmo_cnt = s_r.tmo_cnt + 1'b1;
      if (s_r.tmo_cnt == TMO_C - 1'b1) begin
        s_nxt.tmo_hit = 1'b1;
      end
    end
    if (s_r.cs_st || !s_r.cc2[`MCC_CC2_TMO]) begin
      s_nxt.tmo_hit = 1'b0;
    end

    // Register access; reserved and self-clearing bits never stored
    if (wr_evt) begin
      if (l_r.addr == `MCC_CC1_ADDR) begin
        s_nxt.cc1 = l_r.data & `MCC_CC1_WMASK;
      end else if (l_r.addr == `MCC_CC2_ADDR) begin
        s_nxt.cc2 = l_r.data & `MCC_CC2_WMASK;
      end else if (l_r.addr == `MCC_CC3_ADDR) begin
        s_nxt.cc3 = l_r.data & `MCC_CC3_WMASK;
      end
    end
    if (rd_evt) begin
      if (l_r.addr == `MCC_CC1_ADDR) begin
        s_nxt.rd_hold = s_r.cc1;
      end else if (l_r.addr == `MCC_CC2_ADDR) begin
        s_nxt.rd_hold = s_r.cc2;
      end else if (l_r.addr == `MCC_CC3_ADDR) begin
        s_nxt.rd_hold = s_r.cc3;
      end else begin
        s_nxt.rd_hold = 8'h00;
      end
    end
    if (wr_evt && l_r.addr == `MCC_CC2_ADDR
        && l_r.data[`MCC_CC2_SRST]) begin
      s_nxt.cc1 = `MCC_CC_RST;
      s_nxt.cc2 = `MCC_CC_RST;
      s_nxt.cc3 = `MCC_CC_RST;
      s_nxt.rd_hold = 8'h00;
      s_nxt.srst = 1'b1;
    end

    // Conversion clock only while monitoring and awake
    if (!run) begin
      s_nxt.adc_cnt = '0;
    end else if (s_r.adc_cnt >= adc_per - 1'b1) begin
      s_nxt.adc_cnt = '0;
      s_nxt.adc_tick = 1'b1;
    end else begin
      s_nxt.adc_cnt = s_r.adc_cnt + 1'b1;
    end

    // Falling strobe loads the DACs only when the pin owns updates
    if (s_r.ls_s[1] == s_r.ls_s[2] && !s_r.ls_s[2] && s_r.ls_st
        && !s_r.cc1[`MCC_CC1_PIN9] && !upd_reg
        && !s_r.cc1[`MCC_CC1_PD]) begin
      s_nxt.pin_load = 1'b1;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      s_r <= '0;
      s_r.tg_st <= 1'b0;
      s_r.cs_st <= 1'b1;
      s_r.cs_s <= 3'h7;
      s_r.ls_st <= 1'b1;
      s_r.ls_s <= 3'h7;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign run = s_r.cc1[`MCC_CC1_RUN] && !s_r.cc1[`MCC_CC1_PD];
  assign adc_per = s_r.cc3[`MCC_CC3_FAST] ? FAST_C : SLOW_C;
  // The analog pin function hides the register update source
  assign upd_reg = s_r.cc3[`MCC_CC3_UPDREG]
                   && !s_r.cc1[`MCC_CC1_PIN9];

  assign o_monitor_run = run;
  assign o_single_mode = s_r.cc2[`MCC_CC2_SINGLE];
  assign o_conv_src = src_decode(s_r.cc2[`MCC_CC2_CH +: 3],
    s_r.cc1[`MCC_CC1_PAIR +: 2]);
  assign o_ext_diode_sel =
    s_r.cc1[`MCC_CC1_PAIR +: 2] == `MCC_PAIR_DIODE;
  assign o_ain_pair_sel =
    s_r.cc1[`MCC_CC1_PAIR +: 2] == `MCC_PAIR_AIN;
  assign o_pin9_analog = s_r.cc1[`MCC_CC1_PIN9];
  assign o_standby = s_r.cc1[`MCC_CC1_PD];
  assign o_avg_count = s_r.cc2[`MCC_CC2_AVGDIS] ? `MCC_AVG_ONE
                       : `MCC_AVG_N;
  assign o_bus_timeout = s_r.tmo_hit;
  assign o_soft_reset = s_r.srst;
  assign o_adc_tick = s_r.adc_tick;
  assign o_adc_fast = s_r.cc3[`MCC_CC3_FAST];
  assign o_diode_filter_en = !s_r.cc3[`MCC_CC3_FAST];
  // Eight-bit parts ignore the resolution bit
  assign o_therm_dac_10bit = s_r.cc3[`MCC_CC3_RES10]
                             && (DAC_BITS > 8);
  assign o_dac_reg_update = upd_reg;
  assign o_dac_pin_load = s_r.pin_load;
  assign o_dac_load_strobe_reg_only = upd_reg
    && i_dac_cfg_dac_load_strobe_mode == `MCC_DAC_LOAD_STROBE_REG;
  assign o_adc_ref_vdd = s_r.cc3[`MCC_CC3_REFVDD];
  assign o_dac_a_therm = s_r.cc3[`MCC_CC3_THA];
  assign o_dac_b_therm = s_r.cc3[`MCC_CC3_THB];
  assign o_int_oe = !s_r.cc1[`MCC_CC1_INTDIS];
  assign o_int_out = i_int_event
                     ~^ s_r.cc1[`MCC_CC1_INTPOL];

  a_run_stops: assert property (@(posedge i_sys_clk)
    disable iff (!i_arst_n)
    !s_r.cc1[`MCC_CC1_RUN] |=> !o_adc_tick)
    else $error("conversion tick while stopped");
  a_pair_diode: assert property (@(posedge i_sys_clk)
    disable iff (!i_arst_n)
    o_ext_diode_sel |-> !o_ain_pair_sel)
    else $error("pair select both active");
  a_upd_masked: assert property (@(posedge i_sys_clk)
    disable iff (!i_arst_n)
    o_pin9_analog |-> !o_dac_reg_update && !o_dac_load_strobe_reg_only)
    else $error("update source not masked");
  a_int_off: assert property (@(posedge i_sys_clk)
    disable iff (!i_arst_n)
    s_r.cc1[`MCC_CC1_INTDIS] |-> !o_int_oe)
    else $error("interrupt driven while disabled");
  a_int_low_act: assert property (@(posedge i_sys_clk)
    disable iff (!i_arst_n)
    i_int_event && !s_r.cc1[`MCC_CC1_INTPOL] |-> !o_int_out)
    else $error("interrupt polarity wrong");
  a_standby_halt: assert property (@(posedge i_sys_clk)
    disable iff (!i_arst_n)
    o_standby ##1 o_standby |-> !o_adc_tick && !o_monitor_run)
    else $error("converter active in standby");
  a_chan_ext: assert property (@(posedge i_sys_clk)
    disable iff (!i_arst_n)
    s_r.cc2[2:0] == 3'h2 && o_ext_diode_sel
      |-> o_conv_src == MCC_SRC_TEMP_EXT)
    else $error("channel two source wrong");
  a_avg_single: assert property (@(posedge i_sys_clk)
    disable iff (!i_arst_n)
    s_r.cc2[`MCC_CC2_AVGDIS] |-> o_avg_count == 5'h01)
    else $error("averaging not disabled");
  a_tmo_off: assert property (@(posedge i_sys_clk)
    disable iff (!i_arst_n)
    !s_r.cc2[`MCC_CC2_TMO] |=> !o_bus_timeout)
    else $error("timeout while disabled");
  a_srst_clear: assert property (@(posedge i_sys_clk)
    disable iff (!i_arst_n)
    wr_evt && l_r.addr == `MCC_CC2_ADDR && l_r.data[7]
      |=> o_soft_reset && s_r.cc1 == 8'h00 && s_r.cc3 == 8'h00
          ##1 !o_soft_reset)
    else $error("soft reset incomplete");
  a_srst_rdback: assert property (@(posedge i_sys_clk)
    disable iff (!i_arst_n)
    o_soft_reset |-> !s_r.cc2[`MCC_CC2_SRST] && s_r.rd_hold == 8'h00)
    else $error("soft reset bit reads one");
  a_filter_fast: assert property (@(posedge i_sys_clk)
    disable iff (!i_arst_n)
    o_adc_fast |-> !o_diode_filter_en)
    else $error("diode filter left on");
  a_dac_load_strobe_reg: assert property (@(posedge i_sys_clk)
    disable iff (!i_arst_n)
    o_dac_load_strobe_reg_only |-> o_dac_reg_update && !o_dac_pin_load)
    else $error("register load mode leak");
  a_avg_default: assert property (@(posedge i_sys_clk)
    disable iff (!i_arst_n)
    !s_r.cc2[`MCC_CC2_AVGDIS] |-> o_avg_count == 5'h10)
    else $error("averaging count wrong");
  // Literal bit positions guard the write masks against a slip
  a_rsvd_zero: assert property (@(posedge i_sys_clk)
    disable iff (!i_arst_n)
    1'b1 |-> !s_r.cc1[4] && !s_r.cc2[3] && !s_r.cc3[2] && !s_r.cc3[7])
    else $error("reserved bit stored");

  c_soft_reset: cover property (@(posedge i_sys_clk)
    disable iff (!i_arst_n) o_soft_reset);
  c_read_req: cover property (@(posedge i_sys_clk)
    disable iff (!i_arst_n) rd_evt);
  c_timeout: cover property (@(posedge i_sys_clk)
    disable iff (!i_arst_n) $rose(o_bus_timeout));
  c_pin_load: cover property (@(posedge i_sys_clk)
    disable iff (!i_arst_n) o_dac_pin_load);
endmodule
